// ### hdl/rtc_halt_flags.sv
// Counter halt control, event flag register and countdown timer of the clock module
// Function
// [RULE1] Writing halt one stops counting and clears sub-second prescaler.
// [RULE2] Writing halt zero resumes counting when stop bit is also zero.
// [RULE3] Bus STOP or repeated START during timeout clears halt automatically.
// [RULE4] Host clears both stop and halt to restart counting.
// [RULE5] While halted no time updates, update events or alarm events.
// [RULE6] While halted countdown stalls on 64 Hz, second or minute source.
// [RULE7] While halted countdown keeps running on 4096 Hz source.
// [RULE8] While halted divider stages 2048 Hz to 1 Hz stay reset.
// [RULE9] Flags at bits 5,4,3,1; other bits read zero, ignore writes.
// [RULE10] Update flag sets on update event, holds until written zero.
// [RULE11] Countdown flag sets on countdown event, holds until written zero.
// [RULE12] Alarm flag sets on alarm match, holds until written zero.
// [RULE13] Data-loss flag sets on supply drop, holds until written zero.
// [RULE14] Data-loss flag reads one after cold start.
// [RULE15] Writing one to data-loss flag has no effect.
// [RULE16] Host reinitialises all registers when data-loss flag reads one.
// [RULE17] Host uses halt bit only for clock and calendar purposes.
// [RULE18] Stop bit one halts counting; zero releases when halt zero.
// [RULE19] Interrupt pin low for alarm only with enable, until flag cleared.
// [RULE20] Writing one to update, countdown or alarm flag keeps its value.
`default_nettype none
module rtc_halt_flags
	import rtc_halt_pkg::*;
#(
	parameter int TMO_CYC = BUS_TMO_CYC,
	parameter int PRE_DIV = BASE_DIV
) (
	input wire logic core_clk, // 250 MHz clock
	input wire logic rst_b, // Asynchronous reset, active low
	input wire reg_req_t req, // Register write/read request
	output logic [7:0] rdata, // Read data, cycle after read strobe
	input wire logic bus_start, // Serial bus START seen, pulse
	input wire logic bus_stop, // Serial bus STOP or repeated START, pulse
	input wire logic alarm_match, // Alarm comparator match, pulse
	input wire logic supply_drop, // Supply-drop detector, from a pin
	output logic irq_n_o, // Interrupt pin output value (always low)
	output logic irq_n_oe, // Interrupt pin drive enable
	output logic halted, // Counting stopped
	output logic sec_tick // One-second time update pulse
);
	initial begin
		if (TMO_CYC < 1) $error("rtc_halt_flags: TMO_CYC must be positive");
	end
	logic [1:0] rst_sync;
	logic rst_n;
	logic [1:0] drop_sync;
	logic halt_reg, stop_reg, aie_reg;
	logic upd_f, cnt_f, alm_f, loss_f;
	logic ten_reg;
	tsrc_t tsel_reg;
	logic usel_reg;
	logic [7:0] tload_reg, tcnt_reg;
	logic [$clog2(TMO_CYC+1)-1:0] tmo_reg;
	logic tmo_run;
	logic tick_4096;
	tb_evt_t evt;
	logic upd_evt, cnt_evt, alm_evt, src_tick;
	logic wr_flag, wr_ctrl, wr_tsrc, wr_tload;
	// Reset release through two flops
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) rst_sync <= 2'b00;
		else rst_sync <= {rst_sync[0], 1'b1};
	end
	assign rst_n = rst_sync[1];
	// Supply-drop pin synchroniser
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) drop_sync <= 2'b00;
		else drop_sync <= {drop_sync[0], supply_drop};
	end
	// Write decode
	function automatic logic hit(input reg_req_t r, input logic [3:0] ofs);
		return r.wr && (r.addr == ofs);
	endfunction
	assign wr_flag = hit(req, FLAG_OFS);
	assign wr_ctrl = hit(req, CTRL_OFS);
	assign wr_tsrc = hit(req, TSRC_OFS);
	assign wr_tload = hit(req, TLOAD_OFS);
	// Bus timeout window, opened by START, closed by STOP or expiry
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tmo_reg <= '0;
		end else if (bus_start) begin
			tmo_reg <= $bits(tmo_reg)'(TMO_CYC);
		end else if (bus_stop) begin
			tmo_reg <= '0;
		end else if (tmo_reg != '0) begin
			tmo_reg <= tmo_reg - 1'b1;
		end
	end
	assign tmo_run = (tmo_reg != '0);
	// Halt bit: software write, auto cancel on STOP during timeout
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			halt_reg <= CTRL_RST[HALT_BIT];
		end else if (wr_ctrl) begin
			halt_reg <= req.wdata[HALT_BIT]; // [RULE1] [RULE2]
		end else if (bus_stop && tmo_run) begin
			halt_reg <= 1'b0; // [RULE3]
		end
	end
	// Stop bit and alarm interrupt enable
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			stop_reg <= CTRL_RST[STOP_BIT];
			aie_reg <= CTRL_RST[AIE_BIT];
		end else if (wr_ctrl) begin
			stop_reg <= req.wdata[STOP_BIT]; // [RULE18]
			aie_reg <= req.wdata[AIE_BIT];
		end
	end
	// Halted status; either bit holds counting off
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) halted <= 1'b0;
		else halted <= halt_next_f(halt_reg, stop_reg); // [RULE2] [RULE4] [RULE18]
	end
	function automatic logic halt_next_f(input logic h, input logic s);
		return h | s;
	endfunction
	// Divider chain, held cleared while halt bit is one
	rtc_divider #(
		.PRE_DIV(PRE_DIV)
	) u_div (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.hold(halt_reg | stop_reg), // [RULE1] [RULE8]
		.tick_4096(tick_4096),
		.evt(evt)
	);
	// Time update pulse out, suppressed while halted
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) sec_tick <= 1'b0;
		else sec_tick <= evt.tick_sec & ~halted; // [RULE5]
	end
	assign upd_evt = (usel_reg ? evt.tick_min : evt.tick_sec) & ~halted; // [RULE5]
	assign alm_evt = alarm_match & ~halted; // [RULE5]
	// Countdown source and preset registers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tsel_reg <= tsrc_t'(TSRC_RST[TSEL_LSB +: 2]);
			ten_reg <= TSRC_RST[TEN_BIT];
			usel_reg <= TSRC_RST[5];
			tload_reg <= TLOAD_RST;
		end else begin
			if (wr_tsrc) begin
				tsel_reg <= tsrc_t'(req.wdata[TSEL_LSB +: 2]);
				ten_reg <= req.wdata[TEN_BIT];
				usel_reg <= req.wdata[5];
			end
			if (wr_tload) tload_reg <= req.wdata;
		end
	end
	// Source tick selection for the countdown
	always_comb begin
		unique case (tsel_reg)
			TSRC_4096: src_tick = tick_4096; // [RULE7]
			TSRC_64: src_tick = evt.tick_64 & ~halted; // [RULE6]
			TSRC_SEC: src_tick = evt.tick_sec & ~halted; // [RULE6]
			TSRC_MIN: src_tick = evt.tick_min & ~halted; // [RULE6]
		endcase
	end
	// Countdown, reloads from preset in place of stepping from one to zero
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tcnt_reg <= TLOAD_RST;
		end else if (!ten_reg || wr_tload) begin
			tcnt_reg <= wr_tload ? req.wdata : tload_reg;
		end else if (src_tick) begin
			tcnt_reg <= (tcnt_reg <= 8'h01) ? tload_reg : tcnt_reg - 1'b1;
		end
	end
	assign cnt_evt = ten_reg && src_tick && (tcnt_reg == 8'h01);
	// Event flags: set wins over a zero write; one writes keep value
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			upd_f <= FLAG_RST[UPD_BIT];
			cnt_f <= FLAG_RST[CNT_BIT];
			alm_f <= FLAG_RST[ALM_BIT];
			loss_f <= FLAG_RST[LOSS_BIT]; // [RULE14]
		end else begin
			upd_f <= upd_evt | (upd_f & ~(wr_flag & ~req.wdata[UPD_BIT])); // [RULE10] [RULE20]
			cnt_f <= cnt_evt | (cnt_f & ~(wr_flag & ~req.wdata[CNT_BIT])); // [RULE11] [RULE20]
			alm_f <= alm_evt | (alm_f & ~(wr_flag & ~req.wdata[ALM_BIT])); // [RULE12] [RULE20]
			loss_f <= drop_sync[1] | (loss_f & ~(wr_flag & ~req.wdata[LOSS_BIT])); // [RULE13] [RULE15]
		end
	end
	// Read data, registered, unused bits zero
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= 8'h00;
		end else if (req.rd) begin
			unique case (req.addr)
				FLAG_OFS: begin
					rdata <= 8'h00; // [RULE9]
					rdata[UPD_BIT] <= upd_f;
					rdata[CNT_BIT] <= cnt_f;
					rdata[ALM_BIT] <= alm_f;
					rdata[LOSS_BIT] <= loss_f;
				end
				CTRL_OFS: rdata <= {4'h0, aie_reg, 1'b0, stop_reg, halt_reg};
				TSRC_OFS: rdata <= {2'b00, usel_reg, ten_reg, 2'b00, tsel_reg};
				TLOAD_OFS: rdata <= tload_reg;
				default: rdata <= 8'h00;
			endcase
		end else begin
			rdata <= 8'h00;
		end
	end
	// Open-drain interrupt: drive low while enabled alarm flag stands
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_n_oe <= 1'b0;
			irq_n_o <= 1'b0;
		end else begin
			irq_n_oe <= aie_reg & alm_f; // [RULE19]
			irq_n_o <= 1'b0;
		end
	end
	// Checks
	halt_clears_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(wr_ctrl && req.wdata[HALT_BIT]) |=> ##2 !sec_tick [*8]) // [RULE1]
		else $error("second tick seen shortly after halt");
	resume_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(wr_ctrl && !req.wdata[HALT_BIT] && !req.wdata[STOP_BIT]) |=> ##1 !halted) // [RULE2]
		else $error("not resumed after clearing halt and stop");
	auto_cancel_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(bus_stop && tmo_run && !wr_ctrl) |=> !halt_reg) // [RULE3]
		else $error("halt not cancelled by bus stop");
	no_upd_halt_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(halted && !upd_f && !wr_flag) |=> !upd_f) // [RULE5]
		else $error("update flag set while halted");
	cnt_halt_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(halted && tsel_reg != TSRC_4096 && !wr_tload && ten_reg) |=> $stable(tcnt_reg)) // [RULE6]
		else $error("countdown ran while halted on slow source");
	flag_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(alm_f && !(wr_flag && !req.wdata[ALM_BIT])) |=> alm_f) // [RULE12]
		else $error("alarm flag dropped without zero write");
	loss_one_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(loss_f && wr_flag && req.wdata[LOSS_BIT]) |=> loss_f) // [RULE15]
		else $error("data-loss flag changed by one write");
	irq_alarm_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(aie_reg && alm_f) |=> irq_n_oe) // [RULE19]
		else $error("interrupt not driven for enabled alarm");
endmodule
`default_nettype wire

// ### hdl/rtc_halt_pkg.sv
// Package: register map, field positions, reset values and timing of the halt/flag block
`default_nettype none
package rtc_halt_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	// Register offsets
	localparam logic [3:0] FLAG_OFS = 4'he; // event_flag_status
	localparam logic [3:0] CTRL_OFS = 4'hf; // halt, stop, alarm irq enable
	localparam logic [3:0] TSRC_OFS = 4'hd; // countdown source and enable
	localparam logic [3:0] TLOAD_OFS = 4'hb; // countdown preset
	// Flag field positions
	localparam int UPD_BIT = 5;
	localparam int CNT_BIT = 4;
	localparam int ALM_BIT = 3;
	localparam int LOSS_BIT = 1;
	// Control field positions
	localparam int HALT_BIT = 0;
	localparam int STOP_BIT = 1;
	localparam int AIE_BIT = 3;
	// Countdown source field positions
	localparam int TSEL_LSB = 0;
	localparam int TEN_BIT = 4;
	// Reset values
	localparam logic [7:0] FLAG_RST = 8'h02; // data_loss_flag set after cold start
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] TSRC_RST = 8'h00;
	localparam logic [7:0] TLOAD_RST = 8'h00;
	// Timing
	localparam longint CLK_HZ = 250_000_000;
	localparam longint BASE_HZ = 4096;
	localparam int BASE_DIV = int'((CLK_HZ + BASE_HZ - 1) / BASE_HZ); // cycles per 4096 Hz tick
	localparam real BUS_TMO_S = 0.95;
	localparam int BUS_TMO_CYC = int'(BUS_TMO_S * 250_000_000.0); // 0.95 s in cycles, rounded to nearest
	// Countdown source selection
	typedef enum logic [1:0] {
		TSRC_4096,
		TSRC_64,
		TSRC_SEC,
		TSRC_MIN
	} tsrc_t;
	// Register port request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [3:0] addr;
		logic [7:0] wdata;
	} reg_req_t;
	// Time-base events
	typedef struct packed {
		logic tick_64;
		logic tick_sec;
		logic tick_min;
	} tb_evt_t;
endpackage
`default_nettype wire

// ### hdl/rtc_divider.sv
// Divider chain from 4096 Hz down to 1 Hz with minute count and synchronous hold
`default_nettype none
module rtc_divider
	import rtc_halt_pkg::*;
#(
	parameter int PRE_DIV = BASE_DIV
) (
	input wire logic core_clk, // System clock
	input wire logic rst_n, // Synchronised reset, active low
	input wire logic hold, // Keep 2048 Hz..1 Hz stages cleared
	output logic tick_4096, // 4096 Hz pulse, runs during hold
	output tb_evt_t evt // Divided pulses
);
	initial begin
		if (PRE_DIV < 2) $error("rtc_divider: PRE_DIV must be at least 2");
	end
	logic [$clog2(PRE_DIV)-1:0] pre_reg;
	logic [11:0] chain_reg;
	logic [5:0] sec_reg;
	// Base prescaler, never held
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pre_reg <= '0;
			tick_4096 <= 1'b0;
		end else begin
			tick_4096 <= (pre_reg == $bits(pre_reg)'(PRE_DIV - 1));
			if (pre_reg == $bits(pre_reg)'(PRE_DIV - 1)) pre_reg <= '0;
			else pre_reg <= pre_reg + 1'b1;
		end
	end
	// Ripple stages 2048 Hz to 1 Hz held in reset while halted
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			chain_reg <= '0;
			sec_reg <= '0;
			evt <= '0;
		end else if (hold) begin
			chain_reg <= '0;
			evt <= '0;
		end else begin
			evt <= '0;
			if (tick_4096) begin
				chain_reg <= chain_reg + 1'b1;
				evt.tick_64 <= (chain_reg[5:0] == 6'h3f);
				if (chain_reg == 12'hfff) begin
					evt.tick_sec <= 1'b1;
					if (sec_reg == 6'h3b) begin
						sec_reg <= '0;
						evt.tick_min <= 1'b1;
					end else begin
						sec_reg <= sec_reg + 1'b1;
					end
				end
			end
		end
	end
endmodule
`default_nettype wire

// ### verif/rtc_host_model.sv
// Host controller model: register strobes and serial bus conditions
`default_nettype none
module rtc_host_model
	import rtc_halt_pkg::*;
(
	input wire logic core_clk, // System clock
	output reg_req_t req, // Register request
	output logic bus_start, // START seen pulse
	output logic bus_stop // STOP or repeated START pulse
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle bus at time zero
	initial begin
		req = '0;
		bus_start = 1'b0;
		bus_stop = 1'b0;
	end
	// One-cycle strobe; released lines then carry the inverse pattern
	task automatic access(input logic w, input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk);
		req <= '{wr: w, rd: !w, addr: a, wdata: d};
		@(posedge core_clk);
		req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask
	// One bus condition: start opens the timeout window, else stop
	task automatic cond(input logic st);
		@(posedge core_clk);
		bus_start <= st;
		bus_stop <= !st;
		@(posedge core_clk);
		bus_start <= 1'b0;
		bus_stop <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ### verif/rtc_halt_flags_test.sv
// Self-checking bench of the halt control and event flag block
`default_nettype none
module rtc_halt_flags_test
	import rtc_halt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic alarm_match = 1'b0;
	logic supply_drop = 1'b0;
	reg_req_t req;
	logic bus_start, bus_stop, irq_n_o, irq_n_oe, halted, sec_tick;
	logic [7:0] rdata;
	logic rd_d = 1'b0;
	logic [7:0] exp_q[$];
	int failures = 0;
	int checks_done = 0;
	int seed, n, i;
	wire logic irq_pin = irq_n_oe ? irq_n_o : 1'b1; // Pulled up when released
	always #2 core_clk = ~core_clk;
	rtc_host_model host (.core_clk(core_clk), .req(req), .bus_start(bus_start),
		.bus_stop(bus_stop));
	rtc_halt_flags #(.TMO_CYC(50), .PRE_DIV(4)) DUT (.core_clk(core_clk), .rst_b(rst_b),
		.req(req), .rdata(rdata), .bus_start(bus_start), .bus_stop(bus_stop),
		.alarm_match(alarm_match), .supply_drop(supply_drop), .irq_n_o(irq_n_o),
		.irq_n_oe(irq_n_oe), .halted(halted), .sec_tick(sec_tick));
	task automatic chk_val(input logic [7:0] got, input logic [7:0] exp, input string m);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t %s got %h want %h", $time, m, got, exp);
		end
	endtask
	task automatic chk_pin(input logic got, input logic exp, input string m);
		chk_val({7'h00, got}, {7'h00, exp}, m);
	endtask
	// Read data stand only in the cycle after the strobe
	always @(posedge core_clk) begin
		if (rd_d) begin
			if (exp_q.size() == 0) chk_val(rdata, 8'hxx, "unexpected read");
			else chk_val(rdata, exp_q.pop_front(), "read data");
		end
		rd_d <= req.rd;
	end
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		host.access(1'b1, a, d);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		host.access(1'b0, a, 8'h00);
	endtask
	task automatic settle(input int c);
		repeat (c) @(negedge core_clk);
	endtask
	// Cycles until the next update pulse, capped
	task automatic wait_tick(input int lim, output int k);
		k = 0;
		while (sec_tick !== 1'b1 && k < lim) begin
			@(negedge core_clk);
			k++;
		end
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// Watchdog
	initial begin
		#(4 * 80000);
		failures++;
		$display("BAD t=%0t watchdog expired", $time);
		stop_test();
	end
	initial begin
		seed = 32'h4b0a1d5c;
		repeat (10) @(posedge core_clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge core_clk);
		// Cold start, reserved bits, one-writes
		rd(FLAG_OFS, 8'h02);
		rd(4'h0, 8'h00);
		wr(CTRL_OFS, 8'h00);
		wr(FLAG_OFS, 8'($random(seed)) | 8'h3a);
		rd(FLAG_OFS, 8'h02);
		wr(FLAG_OFS, 8'h00);
		rd(FLAG_OFS, 8'h00);
		@(posedge core_clk) supply_drop <= 1'b1;
		repeat (4) @(posedge core_clk);
		supply_drop <= 1'b0;
		rd(FLAG_OFS, 8'h02);
		wr(FLAG_OFS, 8'h00);
		$display("flag register test done");
		// Alarm with interrupt enable off, then on
		for (i = 0; i < 2; i++) begin
			wr(CTRL_OFS, i[0] ? 8'h08 : 8'h00);
			@(posedge core_clk) alarm_match <= 1'b1;
			@(posedge core_clk) alarm_match <= 1'b0;
			settle(3);
			chk_pin(irq_pin, !i[0], "irq level");
			wr(FLAG_OFS, 8'h08);
			rd(FLAG_OFS, 8'h08);
			wr(FLAG_OFS, 8'h00);
			settle(3);
			chk_pin(irq_pin, 1'b1, "irq release");
		end
		$display("alarm test done");
		// Halted: 4096 Hz countdown runs, slower sources stall
		wr(CTRL_OFS, 8'h01);
		settle(3);
		chk_pin(halted, 1'b1, "halt");
		wr(TLOAD_OFS, 8'h03);
		wr(TSRC_OFS, 8'h10);
		repeat (40) @(posedge core_clk);
		rd(FLAG_OFS, 8'h10);
		wr(TSRC_OFS, 8'h00);
		wr(FLAG_OFS, 8'h00);
		for (i = 1; i < 4; i++) begin
			wr(TSRC_OFS, 8'h10 | 8'(i));
			repeat (2000) @(posedge core_clk);
			rd(FLAG_OFS, 8'h00);
			wr(TSRC_OFS, 8'h00);
		end
		wait_tick(18000, n);
		chk_pin(n >= 18000, 1'b1, "tick while halted");
		rd(FLAG_OFS, 8'h00);
		// Stop bit keeps the halt until both are zero
		wr(CTRL_OFS, 8'h03);
		wr(CTRL_OFS, 8'h02);
		settle(3);
		chk_pin(halted, 1'b1, "stop holds");
		wr(CTRL_OFS, 8'h00);
		settle(3);
		chk_pin(halted, 1'b0, "resume");
		wait_tick(20000, n);
		chk_pin(n > 16360 && n < 16400, 1'b1, "full second after halt");
		settle(2);
		rd(FLAG_OFS, 8'h20);
		wr(FLAG_OFS, 8'h00);
		$display("halt test done");
		// Stop condition inside and outside the timeout window
		for (i = 0; i < 2; i++) begin
			wr(CTRL_OFS, 8'h01);
			host.cond(1'b1);
			repeat (i ? 60 : 10) @(posedge core_clk);
			host.cond(1'b0);
			settle(3);
			chk_pin(halted, i[0], "bus timeout halt");
		end
		wr(CTRL_OFS, 8'h00);
		settle(3);
		$display("bus timeout test done");
		stop_test();
	end
endmodule
`default_nettype wire
